// ---- logic/alf_fault_log.sv ----
`timescale 1ns/10ps
// Contract
// - Keep a fixed-depth alarm logbook readable by the service tool.
// - When full, a new distinct alarm overwrites the oldest entry.
// - Entry holds code, repeat count, first hour meter, first temperature.
// - Repeat of the newest alarm only increments its counter.
// - A repeat leaves the stored hour meter untouched.
// - Lamp on at start-up, then steadily off with no fault.
// - With a fault, flash a fault-specific count repeatedly.
// - Alarm class opens bridge, opens line contactor, applies brake.
// - Warning class keeps power on; only derate follows.
// - Each alarm carries emergency, display, maker codes and blink count.
module alf_fault_log (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic                        alarm_valid,
  input  wire logic [alf_pkg::CODE_W-1:0]  alarm_code,
  input  wire logic                        alarm_is_alarm,
  input  wire logic [15:0]                 alarm_emcy_code,
  input  wire logic [7:0]                  alarm_display_unit_code,
  input  wire logic [7:0]                  alarm_maker_code,
  input  wire logic [alf_pkg::BLINK_W-1:0] alarm_blinks,
  input  wire logic                        fault_clear,
  input  wire logic [alf_pkg::HOUR_W-1:0]  hour_meter,
  input  wire logic [alf_pkg::TEMP_W-1:0]  inverter_temp,
  input  wire logic [alf_pkg::PTR_W-1:0]   log_rd_index,
  output logic      [alf_pkg::ENTRY_W-1:0] log_rd_data,
  output logic      [alf_pkg::PTR_W:0]     log_fill,
  output logic                             fault_lamp,
  output logic                             bridge_enable,
  output logic                             line_contactor,
  output logic                             electromechanical_brake,
  output logic                             derate,
  output logic      [15:0]                 emcy_code,
  output logic      [7:0]                  display_unit_code,
  output logic      [7:0]                  maker_code
);
  import alf_pkg::*;

  typedef struct packed {
    logic [PTR_W-1:0]   wr_ptr;
    logic [PTR_W:0]     fill;
    logic [PTR_W-1:0]   last_ptr;
    logic [CODE_W-1:0]  last_code;
    logic [CNT_W-1:0]   last_cnt;
    logic [HOUR_W-1:0]  last_hour;
    logic [TEMP_W-1:0]  last_temp;
    logic               fault;
    logic               is_alarm;
    logic [15:0]        emcy;
    logic [7:0]         disp;
    logic [7:0]         maker;
    logic [BLINK_W-1:0] blinks;
    alf_lamp_t          lamp;
    logic [TMR_W-1:0]   tmr;
    logic [BLINK_W-1:0] flash_n;
    logic [15:0]        div;
    logic               lamp_on;
  } alf_state_t;

  alf_state_t st_reg;
  alf_state_t st_next;
  logic               wr_en;
  logic [PTR_W-1:0]   wr_addr;
  logic [ENTRY_W-1:0] wr_data;
  logic               tick;
  logic               repeat_hit;

  alf_log_mem u_mem (
    .clk     (clk),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_addr (log_rd_index),
    .rd_data (log_rd_data)
  );

  // A repeat can only merge while the log holds something.
  assign repeat_hit = alarm_valid && (st_reg.fill != FILL_RST) &&
                      (alarm_code == st_reg.last_code);
  assign tick       = (st_reg.div == 16'(TICK_CYC - 1));

  // Next-state logic for the logbook, the fault class and the lamp.
  always_comb begin
    st_next = st_reg;
    wr_en   = 1'b0;
    wr_addr = st_reg.wr_ptr;
    wr_data = '0;
    st_next.div = tick ? 16'h0000 : 16'(st_reg.div + 16'h0001);
    if (alarm_valid) begin
      if (repeat_hit) begin
        // keep first hour: hour and temp are taken from the shadow copy.
        if (st_reg.last_cnt != CNT_MAX) begin
          st_next.last_cnt = CNT_W'(st_reg.last_cnt + CNT_ONE);
        end
        wr_addr = st_reg.last_ptr;
      end else begin
        // fifo overwrite: the write pointer wraps over the oldest entry.
        st_next.last_ptr  = st_reg.wr_ptr;
        st_next.last_code = alarm_code;
        st_next.last_cnt  = CNT_ONE;
        st_next.last_hour = hour_meter;
        st_next.last_temp = inverter_temp;
        st_next.wr_ptr    = PTR_W'(st_reg.wr_ptr + 1'b1);
        if (st_reg.fill != (PTR_W+1)'(LOG_DEPTH)) begin
          st_next.fill = (PTR_W+1)'(st_reg.fill + 1'b1);
        end
      end
      wr_en   = 1'b1;
      wr_data = {st_next.last_code, st_next.last_cnt,
                 st_next.last_hour, st_next.last_temp};
      st_next.fault    = 1'b1;
      st_next.is_alarm = st_reg.fault ? (st_reg.is_alarm | alarm_is_alarm)
                                      : alarm_is_alarm;
      st_next.emcy     = alarm_emcy_code;
      st_next.disp     = alarm_display_unit_code;
      st_next.maker    = alarm_maker_code;
      st_next.blinks   = alarm_blinks;
    end else if (fault_clear) begin
      // A new alarm in the clear cycle wins, handled above.
      st_next.fault    = 1'b0;
      st_next.is_alarm = 1'b0;
    end
    // Lamp sequencer timers advance on the 1 ms tick; idle starts a flash group at once.
    case (st_reg.lamp)
      LS_STARTUP: begin
        st_next.lamp_on = 1'b1;
        if (tick) begin
          st_next.tmr = TMR_W'(st_reg.tmr + 1'b1);
          if (st_reg.tmr == TMR_W'(STARTUP_TICKS - 1)) begin
            st_next.lamp    = LS_IDLE;
            st_next.lamp_on = 1'b0;
            st_next.tmr     = '0;
          end
        end
      end
      LS_IDLE: begin
        st_next.lamp_on = 1'b0;
        st_next.tmr     = '0;
        if (st_reg.fault && st_reg.blinks != '0) begin
          st_next.lamp    = LS_ON;
          st_next.lamp_on = 1'b1;
          st_next.flash_n = st_reg.blinks;
        end
      end
      LS_ON: begin
        if (tick) begin
          st_next.tmr = TMR_W'(st_reg.tmr + 1'b1);
          if (st_reg.tmr == TMR_W'(ON_TICKS - 1)) begin
            st_next.tmr     = '0;
            st_next.lamp_on = 1'b0;
            st_next.flash_n = BLINK_W'(st_reg.flash_n - 1'b1);
            st_next.lamp    = (st_reg.flash_n == BLINK_W'(1)) ? LS_PAUSE
                                                              : LS_OFF;
          end
        end
      end
      LS_OFF: begin
        if (tick) begin
          st_next.tmr = TMR_W'(st_reg.tmr + 1'b1);
          if (st_reg.tmr == TMR_W'(OFF_TICKS - 1)) begin
            st_next.tmr     = '0;
            st_next.lamp_on = 1'b1;
            st_next.lamp    = LS_ON;
          end
        end
      end
      LS_PAUSE: begin
        if (tick) begin
          st_next.tmr = TMR_W'(st_reg.tmr + 1'b1);
          if (st_reg.tmr == TMR_W'(PAUSE_TICKS - 1)) begin
            st_next.tmr  = '0;
            st_next.lamp = LS_IDLE;
          end
        end
      end
      default: begin
        st_next.lamp = LS_IDLE;
      end
    endcase
  end

  // Whole state registers here; reset takes constants only.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg         <= '0;
      st_reg.lamp    <= LS_STARTUP;
      st_reg.lamp_on <= 1'b1;
      st_reg.wr_ptr  <= PTR_RST;
      st_reg.fill    <= FILL_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // warning keeps power: only the derate output follows a warning.
  assign bridge_enable           = ~(st_reg.fault & st_reg.is_alarm);
  assign line_contactor          = ~(st_reg.fault & st_reg.is_alarm);
  assign electromechanical_brake = st_reg.fault & st_reg.is_alarm;
  assign derate                  = st_reg.fault & ~st_reg.is_alarm;
  assign fault_lamp              = st_reg.lamp_on;
  assign log_fill                = st_reg.fill;
  assign emcy_code               = st_reg.emcy;
  assign display_unit_code       = st_reg.disp;
  assign maker_code              = st_reg.maker;

  chk_repeat_no_alloc: assert property (
    @(posedge clk) disable iff (sys_rst)
    repeat_hit |=> $stable(st_reg.wr_ptr) && $stable(st_reg.fill))
    else $error("repeat alarm allocated a new entry");
  // keep first hour: the word written back must carry the old hour.
  chk_repeat_hour_kept: assert property (
    @(posedge clk) disable iff (sys_rst)
    repeat_hit |-> (wr_data[F_HOUR_LSB +: HOUR_W] == st_reg.last_hour)
      ##1 $stable(st_reg.last_hour))
    else $error("repeat alarm changed stored hour");
  chk_fill_saturate: assert property (
    @(posedge clk) disable iff (sys_rst)
    st_reg.fill <= (PTR_W+1)'(LOG_DEPTH))
    else $error("logbook fill above depth");
  chk_new_advances: assert property (
    @(posedge clk) disable iff (sys_rst)
    alarm_valid && !repeat_hit |=> st_reg.last_cnt == CNT_ONE &&
      st_reg.wr_ptr == PTR_W'($past(st_reg.wr_ptr) + 1'b1))
    else $error("new alarm did not advance pointer");
  chk_alarm_opens: assert property (
    @(posedge clk) disable iff (sys_rst)
    alarm_valid && alarm_is_alarm |=> !bridge_enable && !line_contactor &&
      electromechanical_brake)
    else $error("alarm did not open power stage");
  // warning keeps power: judged from the event, not from derate itself.
  chk_warning_power: assert property (
    @(posedge clk) disable iff (sys_rst)
    alarm_valid && !alarm_is_alarm && !st_reg.is_alarm
      |=> derate && bridge_enable && line_contactor &&
          !electromechanical_brake)
    else $error("warning opened power stage");
  chk_idle_dark: assert property (
    @(posedge clk) disable iff (sys_rst)
    st_reg.lamp == LS_IDLE |-> !fault_lamp)
    else $error("lamp lit while idle");
  chk_flash_load: assert property (
    @(posedge clk) disable iff (sys_rst)
    st_reg.lamp == LS_IDLE && st_reg.fault && st_reg.blinks != '0
      |=> fault_lamp && st_reg.flash_n == $past(st_reg.blinks))
    else $error("flash group not started with blink count");
  chk_pause_dark: assert property (
    @(posedge clk) disable iff (sys_rst)
    st_reg.lamp == LS_PAUSE |-> !fault_lamp)
    else $error("lamp lit during pause");
  chk_codes_follow: assert property (
    @(posedge clk) disable iff (sys_rst)
    alarm_valid |=> emcy_code == $past(alarm_emcy_code) &&
      maker_code == $past(alarm_maker_code))
    else $error("indication codes not captured");

  cov_repeat: cover property (@(posedge clk) repeat_hit);
  cov_full_wrap: cover property (@(posedge clk)
    st_reg.fill == (PTR_W+1)'(LOG_DEPTH) && alarm_valid && !repeat_hit);
  cov_pause: cover property (@(posedge clk) st_reg.lamp == LS_PAUSE);
  cov_warning: cover property (@(posedge clk) derate);

endmodule : alf_fault_log

// ---- logic/alf_pkg.sv ----
package alf_pkg;

  // Logbook geometry and field widths.
  localparam int          LOG_DEPTH    = 8;
  localparam int          PTR_W        = 3;
  localparam int          CODE_W       = 8;
  localparam int          CNT_W        = 8;
  localparam int          HOUR_W       = 24;
  localparam int          TEMP_W       = 8;
  localparam int          ENTRY_W      = CODE_W + CNT_W + HOUR_W + TEMP_W;
  localparam int          BLINK_W      = 4;

  // Field positions inside a stored entry.
  localparam int          F_TEMP_LSB   = 0;
  localparam int          F_HOUR_LSB   = TEMP_W;
  localparam int          F_CNT_LSB    = TEMP_W + HOUR_W;
  localparam int          F_CODE_LSB   = TEMP_W + HOUR_W + CNT_W;

  // Reset values and repeat counter start and limit.
  localparam logic [PTR_W-1:0]  PTR_RST   = 3'h0;
  localparam logic [PTR_W:0]    FILL_RST  = 4'h0;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 8'h01;
  localparam logic [CNT_W-1:0]  CNT_MAX   = 8'hff;

  // Example fieldbus emergency code and blink count of the watchdog alarm.
  localparam logic [15:0]        WDOG_EMCY  = 16'h6010;
  localparam logic [BLINK_W-1:0] WDOG_BLINK = 4'h1;

  // Lamp timing in milliseconds and derived tick cycle and tick counts at 25 MHz.
  localparam longint CLK_HZ        = 25000000;
  localparam longint STARTUP_MS    = 1000;
  localparam longint FLASH_ON_MS   = 250;
  localparam longint FLASH_OFF_MS  = 250;
  localparam longint PAUSE_MS      = 1500;
  localparam longint TICK_MS       = 1;
  localparam int     TICK_CYC      = int'(CLK_HZ * TICK_MS / 1000);
  localparam int     STARTUP_TICKS = int'(STARTUP_MS / TICK_MS);
  localparam int     ON_TICKS      = int'(FLASH_ON_MS / TICK_MS);
  localparam int     OFF_TICKS     = int'(FLASH_OFF_MS / TICK_MS);
  localparam int     PAUSE_TICKS   = int'(PAUSE_MS / TICK_MS);
  localparam int     TMR_W         = 12;

  // Lamp sequencer states.
  typedef enum logic [2:0] {
    LS_STARTUP,
    LS_IDLE,
    LS_ON,
    LS_OFF,
    LS_PAUSE
  } alf_lamp_t;

endpackage : alf_pkg

// ---- logic/alf_log_mem.sv ----
`timescale 1ns/10ps
// Logbook storage; read data leaves through a register.
module alf_log_mem (
  input  wire logic                        clk,
  input  wire logic                        wr_en,
  input  wire logic [alf_pkg::PTR_W-1:0]   wr_addr,
  input  wire logic [alf_pkg::ENTRY_W-1:0] wr_data,
  input  wire logic [alf_pkg::PTR_W-1:0]   rd_addr,
  output logic      [alf_pkg::ENTRY_W-1:0] rd_data
);
  import alf_pkg::*;

  logic [ENTRY_W-1:0] mem [LOG_DEPTH];

  // Synchronous write and registered read; no reset so it maps to RAM.
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule : alf_log_mem

// ---- verification/alf_service_tool.sv ----
`timescale 1ns/10ps
// Service tool model that reads the logbook one slot at a time.
module alf_service_tool (
  input  wire logic                        clk,
  output logic      [alf_pkg::PTR_W-1:0]   log_rd_index,
  input  wire logic [alf_pkg::ENTRY_W-1:0] log_rd_data
);
  import alf_pkg::*;

  // The index starts at slot 0 so the read port never sees an unknown.
  initial begin
    log_rd_index = PTR_RST;
  end

  // logbook read access
  // Two edges pass so the registered answer has settled before sampling.
  task automatic rd(input logic [PTR_W-1:0] idx,
                    output logic [ENTRY_W-1:0] data);
    @(posedge clk);
    log_rd_index <= idx;
    repeat (2) @(posedge clk);
    #1;
    data = log_rd_data;
  endtask : rd
endmodule : alf_service_tool

// ---- verification/testbench.sv ----
`timescale 1ns/10ps
// Self-checking bench for the fault logbook and fault outputs.
module testbench;
  import alf_pkg::*;

  logic clk, sys_rst, av, isa, fclr;
  logic [CODE_W-1:0] code;
  logic [15:0] emcy_i, emcy_code;
  logic [7:0] disp_i, mk_i, display_unit_code, maker_code;
  logic [BLINK_W-1:0] blk;
  logic [HOUR_W-1:0] hour;
  logic [TEMP_W-1:0] temp;
  logic [PTR_W-1:0] idx;
  logic [ENTRY_W-1:0] rdata, e;
  logic [PTR_W:0] fill;
  logic lamp, bridge, lcon, brake, derate;
  int n_mismatch = 0;
  int n_checks = 0;

  alf_fault_log dut_u (
    .clk(clk), .sys_rst(sys_rst), .alarm_valid(av),
    .alarm_code(code), .alarm_is_alarm(isa),
    .alarm_emcy_code(emcy_i), .alarm_display_unit_code(disp_i),
    .alarm_maker_code(mk_i), .alarm_blinks(blk),
    .fault_clear(fclr), .hour_meter(hour), .inverter_temp(temp),
    .log_rd_index(idx), .log_rd_data(rdata), .log_fill(fill),
    .fault_lamp(lamp), .bridge_enable(bridge),
    .line_contactor(lcon), .electromechanical_brake(brake),
    .derate(derate), .emcy_code(emcy_code),
    .display_unit_code(display_unit_code), .maker_code(maker_code)
  );

  alf_service_tool tool_u (
    .clk(clk), .log_rd_index(idx), .log_rd_data(rdata)
  );

  // Clock at 25 MHz.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Compares one value and counts any mismatch.
  task automatic chk(input string nm, input logic [47:0] got,
                     input logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // One-cycle alarm pulse; the indications are derived from the code.
  task automatic ev(input logic [7:0] c, input logic a,
                    input logic [23:0] h, input logic [7:0] t);
    @(posedge clk);
    av <= 1'b1;
    code <= c;
    isa <= a;
    emcy_i <= {8'h60, c};
    disp_i <= c;
    mk_i <= ~c;
    hour <= h;
    temp <= t;
    @(posedge clk);
    av <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : ev

  // First alarm-class event: entry contents, codes and power outputs.
  task automatic t_alarm();
    ev(8'h10, 1'b1, 24'h000123, 8'h2a);
    chk("fill", fill, 48'h1);
    tool_u.rd(3'h0, e);
    chk("entry0", e, {8'h10, CNT_ONE, 24'h000123, 8'h2a});
    chk("emcy", emcy_code, WDOG_EMCY);
    chk("disp", display_unit_code, 48'h10);
    chk("maker", maker_code, 48'hef);
    chk("power", {bridge, lcon, brake}, 48'h1);
  endtask : t_alarm

  // Same code again: counter rises, first hour and temperature stay.
  task automatic t_repeat();
    ev(8'h10, 1'b1, 24'h000999, 8'h55);
    chk("fill", fill, 48'h1);
    tool_u.rd(3'h0, e);
    chk("entry0", e, {8'h10, 8'h02, 24'h000123, 8'h2a});
  endtask : t_repeat

  // Warning class after a clear keeps power devices closed.
  task automatic t_warn();
    @(posedge clk);
    fclr <= 1'b1;
    @(posedge clk);
    fclr <= 1'b0;
    @(posedge clk);
    #1;
    chk("power", {bridge, lcon, brake, derate}, 48'hc);
    ev(8'h44, 1'b0, 24'h000200, 8'h30);
    chk("power", {bridge, lcon, brake, derate}, 48'hd);
    chk("fill", fill, 48'h2);
  endtask : t_warn

  // Fill every slot, then one more drops the oldest entry.
  task automatic t_wrap();
    for (int i = 0; i < 6; i++) ev(8'h20 + 8'(i), 1'b0, 24'h1, 8'h1);
    chk("fill", fill, 48'h8);
    ev(8'h77, 1'b0, 24'h000300, 8'h31);
    chk("fill", fill, 48'h8);
    tool_u.rd(3'h0, e);
    chk("entry0", e, {8'h77, CNT_ONE, 24'h000300, 8'h31});
    tool_u.rd(3'h1, e);
    chk("entry1", e, {8'h44, CNT_ONE, 24'h000200, 8'h30});
  endtask : t_wrap

  // Bound on the whole run.
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end

  // Main sequence.
  initial begin
    sys_rst = 1'b1;
    {av, isa, fclr, code, emcy_i, disp_i, mk_i} = '0;
    blk = WDOG_BLINK;
    hour = '0;
    temp = '0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("lamp", lamp, 48'h1);
    chk("power", {bridge, lcon, brake, derate}, 48'hc);
    chk("fill", fill, 48'h0);
    t_alarm();
    t_repeat();
    t_warn();
    t_wrap();
    wrap_up();
  end
endmodule : testbench
